// ===== hdl/uart_rx_regs.vh
// Register map, field positions, reset values and timing for the receive control block
`ifndef UART_RX_REGS_VH
`define UART_RX_REGS_VH
// Word byte addresses
`define OFS_RX_CTRL_STATUS 5'h00
`define OFS_RX_DATA 5'h04
`define OFS_IRQ_STATUS 5'h08
`define OFS_IRQ_ENABLE 5'h0C
`define OFS_IRQ_CLEAR 5'h10
`define OFS_MODE 5'h14
`define OFS_BAUD_DIV 5'h18
// receive_control_status fields
`define BIT_PORT_ON 7
`define BIT_NINE_BIT 6
`define BIT_SINGLE_RX 5
`define BIT_CONT_RX 4
`define BIT_ADDR_DET 3
`define BIT_FRAMING 2
`define BIT_OVERRUN 1
`define BIT_NINTH 0
`define RCS_RESET 8'h00
// Interrupt status fields
`define IRQ_RX_DONE 0
`define IRQ_FRAMING 1
`define IRQ_OVERRUN 2
`define IRQ_WIDTH 3
// Mode register fields
`define BIT_SYNC_MODE 0
`define BIT_SYNC_MASTER 1
// Default baud divider (cycles per bit)
`define BAUD_DIV_RESET 16'h01B2
`endif

// ===== hdl/sync2.v
// Two flip-flop synchroniser for one level input
`timescale 1ns/1ps
module sync2
(
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Level in and out
    input wire async_in,
    output reg sync_out
);
    reg meta_q;
    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            meta_q <= 1'b1;
            sync_out <= 1'b1;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end
endmodule

// ===== hdl/uart_receive_control.v
// Serial receive control and status block with Avalon-MM register slave
// Function
// - Port on enables port and takes the clock pin as sync master only; data pin never driven; off holds port in reset.
// - Eight-bit control/status register: bits 7..3 R/W, 2..1 read-only, 0 read-only.
// - Framing flag set on bad stop; refreshed by buffer read plus next byte.
// - Overrun flag set on overrun; cleared only by clearing continuous receive.
`timescale 1ns/1ps
`include "uart_rx_regs.vh"
module uart_receive_control
(
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Avalon-MM slave
    input wire [4:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    output reg [31:0] readdata,
    output reg waitrequest,
    // Interrupt
    output reg irq,
    // Serial data pin
    input wire rx_data_in,
    output reg rx_data_out,
    output reg rx_data_oe,
    // Serial clock pin
    input wire tx_clock_in,
    output reg tx_clock_out,
    output reg tx_clock_oe
);
    // ==========================================================
    // Pin synchronisers
    wire rx_s;
    wire ck_s;
    sync2 u_sync_rx (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(rx_data_in),
        .sync_out(rx_s));
    sync2 u_sync_ck (.ref_clk(ref_clk), .reset_n(reset_n), .async_in(tx_clock_in),
        .sync_out(ck_s));

    // ==========================================================
    // Registers
    reg port_on_q, nine_q, single_q, cont_q, addr_det_q;
    reg framing_q, overrun_q, ninth_q;
    reg [7:0] rx_buf_q;
    reg buf_full_q;
    reg [`IRQ_WIDTH-1:0] irq_stat_q, irq_en_q;
    reg sync_mode_q, sync_master_q;
    reg [15:0] div_q;
    reg ack_q;
    reg ck_prev_q;
    // Receiver engine
    localparam ST_IDLE = 2'h0;
    localparam ST_START = 2'h1;
    localparam ST_DATA = 2'h2;
    localparam ST_STOP = 2'h3;
    reg [1:0] state_q;
    reg [15:0] cnt_q;
    reg [3:0] bit_q;
    reg [8:0] shift_q;
    reg done_q;
    reg bad_q;

    // Writes land at the edge that shows waitrequest low
    wire wr = write && ack_q;
    wire rd = read && !ack_q;
    wire wr_rcs = wr && address == `OFS_RX_CTRL_STATUS;
    wire rd_buf = rd && address == `OFS_RX_DATA;
    wire [3:0] nbits = nine_q ? 4'h9 : 4'h8;
    wire run_async = port_on_q && !sync_mode_q && cont_q;
    wire run_sync = port_on_q && sync_mode_q && (cont_q || single_q);
    wire ck_rise = ck_s && !ck_prev_q;
    // Sync master bit clock from divider; slave uses pin clock
    wire sync_tick = sync_master_q ? (cnt_q == 16'h0000) : ck_rise;
    // Address detect drops async nine-bit characters whose ninth bit is clear
    wire drop = addr_det_q && nine_q && !sync_mode_q && !shift_q[8];
    // Byte landing in a full buffer is an overrun
    wire deliver = done_q && !drop;

    // ==========================================================
    // Receive engine
    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 4'h0;
            shift_q <= 9'h000;
            done_q <= 1'b0;
            bad_q <= 1'b0;
            ck_prev_q <= 1'b1;
        end
        // port held in reset while off
        else if (!port_on_q)
        begin
            state_q <= ST_IDLE;
            cnt_q <= 16'h0000;
            bit_q <= 4'h0;
            done_q <= 1'b0;
            bad_q <= 1'b0;
            ck_prev_q <= ck_s;
        end
        else
        begin
            ck_prev_q <= ck_s;
            done_q <= 1'b0;
            if (sync_mode_q)
            begin
                cnt_q <= (cnt_q == 16'h0000) ? div_q - 16'h0001 : cnt_q - 16'h0001;
                if (!run_sync)
                    bit_q <= 4'h0;
                else if (sync_tick)
                begin
                    shift_q <= nine_q ? {rx_s, shift_q[8:1]} : {1'b0, rx_s, shift_q[7:1]};
                    if (bit_q == nbits - 4'h1)
                    begin
                        bit_q <= 4'h0;
                        done_q <= 1'b1;
                        bad_q <= 1'b0;
                    end
                    else
                        bit_q <= bit_q + 4'h1;
                end
            end
            else
            begin
                case (state_q)
                    ST_IDLE:
                    begin
                        if (run_async && !rx_s)
                        begin
                            state_q <= ST_START;
                            // Loads one short of half a bit: start bit rechecked div_q/2 cycles later
                            cnt_q <= {1'b0, div_q[15:1]} - 16'h0001;
                        end
                    end
                    ST_START:
                    begin
                        if (cnt_q != 16'h0000)
                            cnt_q <= cnt_q - 16'h0001;
                        else if (rx_s)
                            state_q <= ST_IDLE;
                        else
                        begin
                            state_q <= ST_DATA;
                            cnt_q <= div_q - 16'h0001;
                            bit_q <= 4'h0;
                        end
                    end
                    ST_DATA:
                    begin
                        if (cnt_q != 16'h0000)
                            cnt_q <= cnt_q - 16'h0001;
                        else
                        begin
                            cnt_q <= div_q - 16'h0001;
                            shift_q <= nine_q ? {rx_s, shift_q[8:1]} : {1'b0, rx_s, shift_q[7:1]};
                            if (bit_q == nbits - 4'h1)
                                state_q <= ST_STOP;
                            bit_q <= bit_q + 4'h1;
                        end
                    end
                    ST_STOP:
                    begin
                        if (cnt_q != 16'h0000)
                            cnt_q <= cnt_q - 16'h0001;
                        else
                        begin
                            state_q <= ST_IDLE;
                            done_q <= 1'b1;
                            bad_q <= !rx_s;
                        end
                    end
                    default:
                        state_q <= ST_IDLE;
                endcase
            end
        end
    end

    // ==========================================================
    // Control, status and bus slave
    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            {port_on_q, nine_q, single_q, cont_q, addr_det_q} <= 5'h00;
            framing_q <= 1'b0;
            overrun_q <= 1'b0;
            ninth_q <= 1'b0;
            rx_buf_q <= 8'h00;
            buf_full_q <= 1'b0;
            irq_stat_q <= 3'h0;
            irq_en_q <= 3'h0;
            sync_mode_q <= 1'b0;
            sync_master_q <= 1'b0;
            div_q <= `BAUD_DIV_RESET;
            ack_q <= 1'b0;
            readdata <= 32'h0000_0000;
            waitrequest <= 1'b1;
            irq <= 1'b0;
        end
        else
        begin
            // One wait state, then answer for one cycle
            ack_q <= (read || write) && !ack_q;
            waitrequest <= !((read || write) && !ack_q);
            if (wr_rcs)
            begin
                port_on_q <= writedata[`BIT_PORT_ON];
                nine_q <= writedata[`BIT_NINE_BIT];
                single_q <= writedata[`BIT_SINGLE_RX];
                cont_q <= writedata[`BIT_CONT_RX];
                addr_det_q <= writedata[`BIT_ADDR_DET];
            end
            // single request self-clears in master mode when continuous is clear
            if (done_q && sync_mode_q && sync_master_q && !cont_q)
                single_q <= 1'b0;
            if (wr && address == `OFS_IRQ_ENABLE)
                irq_en_q <= writedata[`IRQ_WIDTH-1:0];
            if (wr && address == `OFS_MODE)
            begin
                sync_mode_q <= writedata[`BIT_SYNC_MODE];
                sync_master_q <= writedata[`BIT_SYNC_MASTER];
            end
            if (wr && address == `OFS_BAUD_DIV)
                div_q <= writedata[15:0];
            if (rd_buf)
                buf_full_q <= 1'b0;
            if (deliver && !(buf_full_q && !rd_buf))
            begin
                rx_buf_q <= shift_q[7:0];
                ninth_q <= shift_q[8];
                buf_full_q <= 1'b1;
                // framing refreshed with each delivered byte that is stored in the buffer
                framing_q <= bad_q;
            end
            // overrun sticky until continuous cleared; set wins
            if (deliver && buf_full_q && !rd_buf)
                overrun_q <= 1'b1;
            else if (wr_rcs && !writedata[`BIT_CONT_RX])
                overrun_q <= 1'b0;
            // Sticky interrupt status, set beats clear
            irq_stat_q <= (irq_stat_q & ~((wr && address == `OFS_IRQ_CLEAR) ?
                writedata[`IRQ_WIDTH-1:0] : 3'h0)) |
                {deliver && buf_full_q && !rd_buf, deliver && bad_q, deliver};
            irq <= |(irq_stat_q & irq_en_q);
            readdata <= 32'h0000_0000;
            if (rd)
            begin
                case (address)
                    `OFS_RX_CTRL_STATUS:
                        readdata <= {24'h000000, port_on_q, nine_q, single_q, cont_q,
                            addr_det_q, framing_q, overrun_q, ninth_q};
                    `OFS_RX_DATA: readdata <= {24'h000000, rx_buf_q};
                    `OFS_IRQ_STATUS: readdata <= {29'h0000000, irq_stat_q};
                    `OFS_IRQ_ENABLE: readdata <= {29'h00000000, irq_en_q};
                    `OFS_MODE: readdata <= {30'h0000000, sync_master_q, sync_mode_q};
                    `OFS_BAUD_DIV: readdata <= {16'h0000, div_q};
                    default: readdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // ==========================================================
    // Pin takeover
    always @(posedge ref_clk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            rx_data_out <= 1'b0;
            rx_data_oe <= 1'b0;
            tx_clock_out <= 1'b1;
            tx_clock_oe <= 1'b0;
        end
        else
        begin
            rx_data_out <= 1'b0;
            rx_data_oe <= 1'b0;
            // clock pin driven only as sync master with port on
            tx_clock_oe <= port_on_q && sync_mode_q && sync_master_q;
            tx_clock_out <= (cnt_q >= {1'b0, div_q[15:1]});
        end
    end
endmodule

// ===== dv/uart_rx_chk.sv
// Assertion checker bound to the receive control block
`timescale 1ns/1ps
module uart_rx_chk
(
    // Clock and reset
    input wire ref_clk,
    input wire reset_n,
    // Avalon-MM slave
    input wire [4:0] address,
    input wire read,
    input wire write,
    input wire [31:0] writedata,
    input wire [31:0] readdata,
    input wire waitrequest,
    // Interrupt and pins
    input wire irq,
    input wire rx_data_in,
    input wire rx_data_out,
    input wire rx_data_oe,
    input wire tx_clock_in,
    input wire tx_clock_out,
    input wire tx_clock_oe
);
// ==========
// Shadow of the last control write
wire ctrl_wr = write && !waitrequest && address == 5'h00;
wire ctrl_rd = read && !waitrequest && address == 5'h00;
reg [7:3] ctl_q;
reg ovr_q;
always @(posedge ref_clk or negedge reset_n)
begin
    if (!reset_n)
    begin
        ctl_q <= 5'h00;
        ovr_q <= 1'h0;
    end
    else if (ctrl_wr)
    begin
        ctl_q <= writedata[7:3];
        ovr_q <= ovr_q && writedata[4];
    end
    else if (ctrl_rd && readdata[1])
        ovr_q <= 1'h1;
end
// ==========
// Properties
default clocking cb @(posedge ref_clk); endclocking
default disable iff (!reset_n);
chk_ctrl_fields:
    assert property (ctrl_rd |-> readdata[31:8] == 24'h0 && readdata[7:6] == ctl_q[7:6]
        && readdata[4:3] == ctl_q[4:3]) else $error("bad control readback");
chk_overrun_sticky:
    assert property (ctrl_rd && ovr_q |-> readdata[1]) else $error("overrun flag lost");
chk_clock_pin_on:
    assert property (tx_clock_oe |-> ctl_q[7] || $past(ctl_q[7])) else $error("pin taken while off");
chk_data_pin_free:
    assert property (!rx_data_oe && !rx_data_out) else $error("data pin driven");
chk_single_kept:
    assert property (ctrl_rd |-> (!readdata[5] || ctl_q[5]) && (!(ctl_q[5] && ctl_q[4])
        || readdata[5])) else $error("single request bit wrong");
chk_answer_short:
    assert property ($fell(waitrequest) |=> waitrequest) else $error("answer too long");
chk_answer_soon:
    assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
        else $error("answer late");
chk_idle_readdata:
    assert property (waitrequest |-> readdata == 32'h0) else $error("read data not idle");
cover property (ctrl_rd && readdata[2]);
cover property (ctrl_rd && readdata[1]);
cover property ($rose(irq));
cover property ($rose(tx_clock_out) && tx_clock_oe);
endmodule
bind uart_receive_control uart_rx_chk uart_rx_chk_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata), .readdata(readdata),
    .waitrequest(waitrequest), .irq(irq), .rx_data_in(rx_data_in), .rx_data_out(rx_data_out),
    .rx_data_oe(rx_data_oe), .tx_clock_in(tx_clock_in), .tx_clock_out(tx_clock_out),
    .tx_clock_oe(tx_clock_oe));

// ===== dv/uart_line_model.sv
// Remote serial transmitter model driving the receive pin
`timescale 1ns/1ps
module uart_line_model
(
    // Clock
    input wire ref_clk,
    // Line
    output reg line_out
);
// ==========
// Frame sender
// Idles high, as a line with a pull-up would
initial line_out = 1'h1;
task send(input [8:0] data, input integer bits, input stop_ok, input integer div);
    integer i;
    begin
        for (i = 0; i < bits + 3; i = i + 1)
        begin
            @(posedge ref_clk);
            line_out <= (i == 0) ? 1'h0 : (i <= bits) ? data[i - 1] :
                (i == bits + 1) ? stop_ok : 1'h1;
            repeat (div - 1) @(posedge ref_clk);
        end
    end
endtask
endmodule

// ===== dv/tb.sv
// Self-checking bench for the receive control block
`timescale 1ns/1ps
module tb;
// ==========
// Signals and instances
reg ref_clk = 1'h0;
reg reset_n = 1'h0;
reg [4:0] address = 5'h00;
reg read = 1'h0;
reg write = 1'h0;
reg [31:0] writedata = 32'h0;
reg tx_clock_in = 1'h0;
wire [31:0] readdata;
wire waitrequest, irq, rx_data_out, rx_data_oe, tx_clock_out, tx_clock_oe, line;
integer fails = 0;
integer comparisons = 0;
integer i;
reg [31:0] rd;
reg [20:0] row [0:4];
always #10 ref_clk = ~ref_clk;
uart_line_model uart_line_model_i (.ref_clk(ref_clk), .line_out(line));
uart_receive_control uart_receive_control_i (.ref_clk(ref_clk), .reset_n(reset_n),
    .address(address), .read(read), .write(write), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .irq(irq), .rx_data_in(line),
    .rx_data_out(rx_data_out), .rx_data_oe(rx_data_oe), .tx_clock_in(tx_clock_in),
    .tx_clock_out(tx_clock_out), .tx_clock_oe(tx_clock_oe));
// ==========
// Tasks
task complete_run;
    begin
        $display("comparisons %0d fails %0d", comparisons, fails);
        if (fails == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    end
endtask
task check(input [31:0] got, input [31:0] exp);
    begin
        comparisons = comparisons + 1;
        if (got !== exp)
        begin
            fails = fails + 1;
            $display("CHECK FAILED %0t got %h expected %h", $time, got, exp);
        end
    end
endtask
// Holds the request until waitrequest is seen low, then idles two cycles
// so that registered outputs have settled when the caller looks
task bus(input wr, input [4:0] a, input [31:0] d);
    integer n;
    begin
        n = 0;
        address <= a;
        writedata <= d;
        read <= !wr;
        write <= wr;
        do
        begin
            @(posedge ref_clk);
            n = n + 1;
        end
        while (waitrequest !== 1'h0 && n < 50);
        if (waitrequest !== 1'h0)
        begin
            fails = fails + 1;
            complete_run;
        end
        rd = readdata;
        read <= 1'h0;
        write <= 1'h0;
        repeat (2) @(posedge ref_clk);
    end
endtask
task wait_bit(input [4:0] a, input integer b, input v);
    integer n;
    begin
        n = 0;
        do
        begin
            bus(0, a, 32'h0);
            n = n + 1;
        end
        while (rd[b] !== v && n < 300);
        check(rd[b], v);
        if (rd[b] !== v)
            complete_run;
    end
endtask
// ==========
// Main sequence
initial
begin
    row[0] = {5'h00, 8'hFF, 8'hF8};
    row[1] = {5'h00, 8'h07, 8'h00};
    row[2] = {5'h0C, 8'h07, 8'h07};
    row[3] = {5'h1C, 8'hA5, 8'h00};
    row[4] = {5'h18, 8'h10, 8'h10};
    repeat (16) @(posedge ref_clk);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    for (i = 0; i < 5; i = i + 1)
    begin
        bus(1, row[i][20:16], {24'h0, row[i][15:8]});
        bus(0, row[i][20:16], 32'h0);
        check(rd, {24'h0, row[i][7:0]});
    end
    reset_n <= 1'h0;
    repeat (3) @(posedge ref_clk);
    check({waitrequest, irq}, 32'h2);
    reset_n <= 1'h1;
    @(posedge ref_clk);
    bus(0, 5'h00, 32'h0);
    check(rd, 32'h0);
    bus(0, 5'h18, 32'h0);
    check(rd, 32'h1B2);
    bus(1, 5'h18, 32'h10);
    bus(1, 5'h14, 32'h3);
    bus(1, 5'h00, 32'h80);
    check(tx_clock_oe, 32'h1);
    rd = tx_clock_out;
    repeat (8) @(posedge ref_clk);
    check(tx_clock_out, !rd[0]);
    bus(1, 5'h00, 32'h0);
    check({tx_clock_oe, rx_data_oe}, 32'h0);
    // Sync master: single byte, then continuous until overrun
    bus(1, 5'h00, 32'hA0);
    wait_bit(5'h00, 5, 0);
    bus(0, 5'h08, 32'h0);
    check(rd & 32'h1, 32'h1);
    bus(0, 5'h04, 32'h0);
    check(rd, 32'hFF);
    bus(1, 5'h00, 32'hB0);
    wait_bit(5'h00, 1, 1);
    bus(1, 5'h00, 32'hB0);
    bus(0, 5'h04, 32'h0);
    bus(0, 5'h00, 32'h0);
    check(rd & 32'hFE, 32'hB2);
    bus(1, 5'h00, 32'h80);
    bus(0, 5'h00, 32'h0);
    check(rd, 32'h80);
    bus(0, 5'h04, 32'h0);
    // Sync slave: eight pin clock rises fill a byte, single stays set
    bus(1, 5'h14, 32'h1);
    bus(1, 5'h10, 32'h7);
    bus(1, 5'h00, 32'hA0);
    for (i = 0; i < 8; i = i + 1)
    begin
        repeat (4) @(posedge ref_clk);
        tx_clock_in <= 1'h1;
        repeat (4) @(posedge ref_clk);
        tx_clock_in <= 1'h0;
    end
    wait_bit(5'h08, 0, 1);
    bus(0, 5'h04, 32'h0);
    check(rd, 32'hFF);
    bus(0, 5'h00, 32'h0);
    check(rd, 32'hA0);
    // Async framing fault with interrupt raise, mask and clear
    bus(1, 5'h14, 32'h0);
    bus(1, 5'h00, 32'h90);
    bus(1, 5'h10, 32'h7);
    bus(1, 5'h0C, 32'h2);
    uart_line_model_i.send(9'h05A, 8, 0, 16);
    wait_bit(5'h00, 2, 1);
    check(irq, 32'h1);
    bus(1, 5'h0C, 32'h0);
    check(irq, 32'h0);
    bus(1, 5'h0C, 32'h2);
    check(irq, 32'h1);
    bus(1, 5'h10, 32'h2);
    check(irq, 32'h0);
    bus(0, 5'h04, 32'h0);
    check(rd, 32'h5A);
    bus(0, 5'h00, 32'h0);
    check(rd & 32'h4, 32'h4);
    uart_line_model_i.send(9'h03C, 8, 1, 16);
    wait_bit(5'h00, 2, 0);
    bus(0, 5'h04, 32'h0);
    check(rd, 32'h3C);
    // Nine-bit with address detect drops a data character
    bus(1, 5'h00, 32'hD8);
    uart_line_model_i.send(9'h033, 9, 1, 16);
    uart_line_model_i.send(9'h1C3, 9, 1, 16);
    wait_bit(5'h00, 0, 1);
    bus(0, 5'h04, 32'h0);
    check(rd, 32'hC3);
    complete_run;
end
endmodule
